//--- rtl/nvhi_dev.sv
// Validator end: event bytes, commands, pulse output, escrow, low power.
// Assumes the note mechanism reports entry and result on the user side.
//
// Behaviour
// R1 - Entry sends 120; accept sends 121, channel
// R2 - Reject sends 121, 20; return sends 121
// R3 - Inhibit code disables channel, echoed back
// R4 - Uninhibit code enables channel, echoed back
// R5 - Status 182 echoed plus three status bytes
// R6 - Escrow 170 echoed; 172 echoed plus channel
// R7 - Pulse mode emits configurable credit pulses
// R8 - Four disable pins pulled high, low enables
// R9 - No disable pin low blocks all notes; the code checks the pins in pulse mode only
// R10 - Busy output low while handling a note
// R11 - Low power six seconds after power-up
// R12 - Low power again one second after note
// R13 - Credit hold waits escrow low-high per burst
// R14 - Each later burst awaits another toggle
// R15 - Busy low, acceptance blocked during hold
// R16 - Note held until host confirms on escrow
// R17 - Unconfirmed escrow returns note after 30s
// R18 - Start-disabled variant waits for software enable
// R19 - Host confirms vend with escrow toggle
`timescale 1ns/1ps
`default_nettype none
module nvhi_dev #(
  parameter int LP_ENTRY   = nvhi_pkg::LP_ENTRY_CYC,
  parameter int LP_REENTRY = nvhi_pkg::LP_REENTRY_CYC,
  parameter int ESC_TMO    = nvhi_pkg::ESC_TMO_CYC
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Link
  nvhi_if.dev              lnk,
  // Configuration
  input  wire logic        pulse_mode,
  input  wire logic        pulse_escrow,
  input  wire logic        credit_hold,
  input  wire logic        low_power_en,
  input  wire logic        start_disabled,
  input  wire logic [7:0]  pulses_per_burst,
  input  wire logic [15:0] pulse_hi_cyc,
  input  wire logic [15:0] pulse_lo_cyc,
  // Note mechanism
  input  wire logic        note_in,
  input  wire logic        result_valid,
  input  wire logic        result_ok,
  input  wire logic [3:0]  result_chan,
  input  wire logic [4:0]  result_bursts,
  input  wire logic        note_returned,
  output logic             stack_o,
  output logic             return_o,
  output logic             accept_block_o,
  output logic             low_power_o,
  output logic [15:0]      chan_inhibit_o
);
  // Counters cannot serve a zero or negative limit
  if (LP_ENTRY < 1 || LP_REENTRY < 1 || ESC_TMO < 1) begin : g_bad_cnt
    $error("Counts must be positive");
  end

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01, ST_CHECK = 7'h02, ST_HOLD = 7'h04, ST_TOG = 7'h08,
    ST_PHI  = 7'h10, ST_PLO   = 7'h20, ST_RET  = 7'h40
  } nvhi_st_e;

  nvhi_st_e    st_r, st_nxt;
  logic [7:0]  q_r [4], q_nxt [4];
  logic [2:0]  qn_r, qn_nxt;
  logic        rdy_r, rdy_nxt, txv_r, txv_nxt;
  logic [7:0]  txb_r, txb_nxt;
  logic [15:0] inh_r, inh_nxt;
  logic        esc_on_r, esc_on_nxt, tmo_en_r, tmo_en_nxt;
  logic        swblk_r, swblk_nxt, init_r;
  logic [3:0]  chan_r, chan_nxt;
  logic [4:0]  burst_r, burst_nxt;
  logic [7:0]  pcnt_r, pcnt_nxt;
  logic [31:0] tmr_r, tmr_nxt, lp_r, lp_nxt;
  logic        lp_first_r, lp_first_nxt, lpo_r, lpo_nxt;
  logic        pulse_r, pulse_nxt, busy_n_r, busy_n_nxt;
  logic        stk_r, stk_nxt, ret_r, ret_nxt, blk_r, blk_nxt;
  logic [2:0]  dis_s [4];
  logic [2:0]  esc_s;
  logic [3:0]  dis_q;
  logic        esc_q, esc_low_r, esc_low_nxt;
  logic        tog, cmd_take, pinblk, pin_off;

  // Three-stage pin sync; a level counts once stages two and three agree
  genvar g;
  for (g = 0; g < 4; g++) begin : g_dis
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        dis_s[g] <= 3'h7;
        dis_q[g] <= 1'b1;
      end else begin
        dis_s[g] <= {dis_s[g][1:0], lnk.dis_n[g]};
        if (dis_s[g][1] == dis_s[g][2]) dis_q[g] <= dis_s[g][2]; // R8
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      esc_s <= 3'h7;
      esc_q <= 1'b1;
    end else begin
      esc_s <= {esc_s[1:0], lnk.escrow};
      if (esc_s[1] == esc_s[2]) esc_q <= esc_s[2];
    end
  end

  // Low-then-high on the escrow line is one confirmation
  assign tog      = esc_low_r & esc_q; // R19
  assign pinblk   = pulse_mode & (&dis_q); // R9
  // In pulse mode, channels one to four also need their own line pulled low
  assign pin_off  = pulse_mode & (result_chan < 4'd4) & dis_q[result_chan[1:0]]; // R8
  assign cmd_take = lnk.h2d_valid & rdy_r & ~pulse_mode;

  // All next-state logic; bytes are pushed only into an empty queue
  always_comb begin
    logic       push_ok;
    logic [7:0] b;
    push_ok = (qn_r == 3'd0) && !cmd_take;
    b = lnk.h2d_byte;
    st_nxt = st_r; qn_nxt = qn_r; q_nxt = q_r;
    inh_nxt = inh_r; esc_on_nxt = esc_on_r; tmo_en_nxt = tmo_en_r;
    swblk_nxt = swblk_r; chan_nxt = chan_r; burst_nxt = burst_r;
    pcnt_nxt = pcnt_r; tmr_nxt = tmr_r; pulse_nxt = 1'b0;
    stk_nxt = 1'b0; ret_nxt = 1'b0;
    esc_low_nxt = tog ? 1'b0 : (esc_low_r | ~esc_q);
    txv_nxt = 1'b0; txb_nxt = txb_r;
    // Drain one queued byte a cycle
    if (qn_r != 3'd0) begin
      txv_nxt = 1'b1; txb_nxt = q_r[0];
      q_nxt[0] = q_r[1]; q_nxt[1] = q_r[2]; q_nxt[2] = q_r[3];
      qn_nxt = qn_r - 3'd1;
    end
    // Host commands, each answered by its echo or, if unknown, by the error code
    if (cmd_take) begin
      q_nxt[0] = b; qn_nxt = 3'd1;
      if (b >= nvhi_pkg::C_INH_BASE && b < nvhi_pkg::C_INH_BASE + 8'd16)
        inh_nxt[4'(b - nvhi_pkg::C_INH_BASE)] = 1'b1; // R3
      else if (b >= nvhi_pkg::C_UNINH_BSE && b < nvhi_pkg::C_UNINH_BSE + 8'd16)
        inh_nxt[4'(b - nvhi_pkg::C_UNINH_BSE)] = 1'b0; // R4
      else if (b == nvhi_pkg::C_STATUS) begin
        q_nxt[1] = inh_r[7:0]; q_nxt[2] = inh_r[15:8]; // R5
        q_nxt[3] = {7'h00, esc_on_r}; qn_nxt = 3'd4;
      end else if (b == nvhi_pkg::C_ESC_ON) esc_on_nxt = 1'b1; // R6
      else if (b == nvhi_pkg::C_ESC_OFF) esc_on_nxt = 1'b0;
      else if (b == nvhi_pkg::C_EN_ALL) begin
        swblk_nxt = 1'b0; inh_nxt = 16'h0000; // R18
      end else if (b == nvhi_pkg::C_DIS_ALL) swblk_nxt = 1'b1;
      else if (b == nvhi_pkg::C_TMO_OFF) tmo_en_nxt = 1'b0;
      else if (b == nvhi_pkg::C_TMO_ON) tmo_en_nxt = 1'b1;
      else if (b != nvhi_pkg::C_ESC_ACC && b != nvhi_pkg::C_ESC_REJ)
        q_nxt[0] = nvhi_pkg::C_CMD_ERR;
    end
    case (st_r)
      ST_IDLE: if (note_in && push_ok) begin
        st_nxt = ST_CHECK;
        if (!pulse_mode) begin q_nxt[0] = nvhi_pkg::C_BUSY; qn_nxt = 3'd1; end // R1
      end
      ST_CHECK: if (result_valid && push_ok) begin
        chan_nxt = result_chan; tmr_nxt = 32'd0;
        burst_nxt = (result_bursts == 5'd0) ? 5'd1 : result_bursts;
        // Blocking sources only; this note's own busy state must not refuse it
        if (!result_ok || inh_r[result_chan] || swblk_r || pinblk || pin_off) begin // R8 R9
          st_nxt = ST_RET; ret_nxt = 1'b1;
          if (!pulse_mode) begin
            q_nxt[0] = nvhi_pkg::C_READY; q_nxt[1] = nvhi_pkg::C_REJECT; qn_nxt = 3'd2; // R2
          end
        end else if (pulse_mode) begin
          st_nxt = pulse_escrow ? ST_HOLD : (credit_hold ? ST_TOG : ST_PHI); // R16
          if (!pulse_escrow) stk_nxt = 1'b1;
        end else begin
          q_nxt[0] = nvhi_pkg::C_READY; qn_nxt = 3'd2; // R1
          q_nxt[1] = {4'h0, result_chan} + 8'd1;
          if (esc_on_r) st_nxt = ST_HOLD; // R6
          else begin st_nxt = ST_IDLE; stk_nxt = 1'b1; end
        end
      end
      ST_HOLD: begin
        tmr_nxt = tmr_r + 32'd1;
        if (tmo_en_r && tmr_r >= 32'(ESC_TMO - 1)) begin
          st_nxt = ST_RET; ret_nxt = 1'b1; // R17
        end else if (pulse_mode && tog) begin
          stk_nxt = 1'b1; st_nxt = credit_hold ? ST_TOG : ST_PHI; // R16
        end else if (cmd_take && b == nvhi_pkg::C_ESC_ACC) begin
          q_nxt[1] = {4'h0, chan_r} + 8'd1; qn_nxt = 3'd2; // R6
          stk_nxt = 1'b1; st_nxt = ST_IDLE;
        end else if (cmd_take && b == nvhi_pkg::C_ESC_REJ) begin
          ret_nxt = 1'b1; st_nxt = ST_RET;
        end
      end
      ST_TOG: if (tog) st_nxt = ST_PHI; // R13 R14
      ST_PHI: begin
        pulse_nxt = 1'b1; tmr_nxt = tmr_r + 32'd1; // R7
        if (tmr_r[15:0] + 16'd1 >= pulse_hi_cyc) begin
          st_nxt = ST_PLO; tmr_nxt = 32'd0;
        end
      end
      ST_PLO: begin
        tmr_nxt = tmr_r + 32'd1;
        if (tmr_r[15:0] + 16'd1 >= pulse_lo_cyc) begin
          tmr_nxt = 32'd0; pcnt_nxt = pcnt_r + 8'd1; st_nxt = ST_PHI;
          if (pcnt_r + 8'd1 >= pulses_per_burst) begin
            pcnt_nxt = 8'd0; burst_nxt = burst_r - 5'd1;
            if (burst_r == 5'd1) st_nxt = ST_IDLE;
            else if (credit_hold) st_nxt = ST_TOG; // R14
          end
        end
      end
      ST_RET: if (note_returned && push_ok) begin
        st_nxt = ST_IDLE;
        if (!pulse_mode) begin q_nxt[0] = nvhi_pkg::C_READY; qn_nxt = 3'd1; end // R2
      end
      default: st_nxt = ST_IDLE;
    endcase
    rdy_nxt = (qn_nxt == 3'd0);
    busy_n_nxt = (st_nxt == ST_IDLE); // R10 R15
    blk_nxt = swblk_nxt | pinblk | (st_nxt != ST_IDLE); // R9 R15
    // Low-power timer: long after power-up, short after each note
    lp_first_nxt = lp_first_r; lp_nxt = lp_r; lpo_nxt = lpo_r;
    if (!low_power_en || st_r != ST_IDLE || note_in) begin
      lp_nxt = 32'd0; lpo_nxt = 1'b0;
      if (st_r != ST_IDLE) lp_first_nxt = 1'b0;
    end else if (!lpo_r) begin
      lp_nxt = lp_r + 32'd1;
      if (lp_r + 32'd1 >= (lp_first_r ? 32'(LP_ENTRY) : 32'(LP_REENTRY)))
        lpo_nxt = 1'b1; // R11 R12
    end
  end

  // State registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= ST_IDLE; qn_r <= 3'd0; rdy_r <= 1'b0;
      for (int i = 0; i < 4; i++) q_r[i] <= 8'h00;
      txv_r <= 1'b0; txb_r <= 8'h00; inh_r <= 16'h0000;
      esc_on_r <= 1'b0; tmo_en_r <= 1'b1; swblk_r <= 1'b0; init_r <= 1'b0;
      chan_r <= 4'h0; burst_r <= 5'd0; pcnt_r <= 8'd0; tmr_r <= 32'd0;
      lp_r <= 32'd0; lp_first_r <= 1'b1; lpo_r <= 1'b0; pulse_r <= 1'b0;
      busy_n_r <= 1'b1; stk_r <= 1'b0; ret_r <= 1'b0; blk_r <= 1'b1;
      esc_low_r <= 1'b0;
    end else begin
      st_r <= st_nxt; qn_r <= qn_nxt; q_r <= q_nxt; rdy_r <= rdy_nxt;
      txv_r <= txv_nxt; txb_r <= txb_nxt; inh_r <= inh_nxt;
      esc_on_r <= esc_on_nxt; tmo_en_r <= tmo_en_nxt;
      // Strap caught on the first edge after release
      init_r <= 1'b1;
      swblk_r <= init_r ? swblk_nxt : start_disabled; // R18
      chan_r <= chan_nxt; burst_r <= burst_nxt; pcnt_r <= pcnt_nxt; tmr_r <= tmr_nxt;
      lp_r <= lp_nxt; lp_first_r <= lp_first_nxt; lpo_r <= lpo_nxt;
      pulse_r <= pulse_nxt; busy_n_r <= busy_n_nxt; stk_r <= stk_nxt; ret_r <= ret_nxt;
      blk_r <= blk_nxt; esc_low_r <= esc_low_nxt;
    end
  end

  // Outputs straight from flops
  assign lnk.d_rx_ready   = rdy_r;
  assign lnk.d2h_byte     = txb_r;
  assign lnk.d2h_valid    = txv_r;
  assign lnk.credit_pulse = pulse_r;
  assign lnk.busy_n       = busy_n_r;
  assign stack_o          = stk_r;
  assign return_o         = ret_r;
  assign accept_block_o   = blk_r;
  assign low_power_o      = lpo_r;
  assign chan_inhibit_o   = inh_r;
endmodule // nvhi_dev
`default_nettype wire

//--- rtl/nvhi_pkg.sv
// Shared constants of the note validator host link: event codes,
// timing counts at the system clock and the controller register map.
// Assumes a single 10 MHz clock on both ends.
`default_nettype none
package nvhi_pkg;
  // Clock and times
  localparam int CLK_HZ         = 10_000_000;
  localparam int CYC_PER_MS     = CLK_HZ / 1000;
  localparam int LP_ENTRY_MS    = 6000;
  localparam int LP_REENTRY_MS  = 1000;
  localparam int ESC_TIMEOUT_MS = 30000;
  localparam int LP_ENTRY_CYC   = LP_ENTRY_MS * CYC_PER_MS;
  localparam int LP_REENTRY_CYC = LP_REENTRY_MS * CYC_PER_MS;
  localparam int ESC_TMO_CYC    = ESC_TIMEOUT_MS * CYC_PER_MS;
  localparam int TOGGLE_US      = 100;
  localparam int TOGGLE_CYC     = TOGGLE_US * (CLK_HZ / 1_000_000);
  // Event and command codes
  localparam logic [7:0] C_REJECT    = 8'h14;
  localparam logic [7:0] C_BUSY      = 8'h78;
  localparam logic [7:0] C_READY     = 8'h79;
  localparam logic [7:0] C_INH_BASE  = 8'h83;
  localparam logic [7:0] C_UNINH_BSE = 8'h97;
  localparam logic [7:0] C_ESC_ON    = 8'haa;
  localparam logic [7:0] C_ESC_OFF   = 8'hab;
  localparam logic [7:0] C_ESC_ACC   = 8'hac;
  localparam logic [7:0] C_ESC_REJ   = 8'had;
  localparam logic [7:0] C_STATUS    = 8'hb6;
  localparam logic [7:0] C_EN_ALL    = 8'hb8;
  localparam logic [7:0] C_DIS_ALL   = 8'hb9;
  localparam logic [7:0] C_TMO_OFF   = 8'hbe;
  localparam logic [7:0] C_TMO_ON    = 8'hbf;
  localparam logic [7:0] C_CMD_ERR   = 8'hff;
  // Controller registers (byte addresses)
  localparam logic [7:0] A_CMD    = 8'h00;
  localparam logic [7:0] A_RXBYTE = 8'h04;
  localparam logic [7:0] A_STAT   = 8'h08;
  localparam logic [7:0] A_MASK   = 8'h0c;
  localparam logic [7:0] A_CTRL   = 8'h10;
  localparam logic [7:0] A_PULSES = 8'h14;
  // Status bits
  localparam int S_RX    = 0;
  localparam int S_PULSE = 1;
  localparam int S_IDLE  = 2;
  localparam int S_ERR   = 3;
  localparam int NSTAT   = 4;
  // Control fields
  localparam int CTRL_TOG = 4;
endpackage
`default_nettype wire

//--- rtl/nvhi_if.sv
// Link between the validator end and the host controller end.
// Pull-ups of the disable lines are resolved here from the enables.
`timescale 1ns/1ps
`default_nettype none
interface nvhi_if;
  logic [7:0] h2d_byte;
  logic       h2d_valid;
  logic       d_rx_ready;
  logic [7:0] d2h_byte;
  logic       d2h_valid;
  logic       credit_pulse;
  logic       busy_n;
  logic [3:0] dis_o;
  logic [3:0] dis_oe_n;
  logic [3:0] dis_n;
  logic       escrow;

  // Open-drain lines rest high when nobody pulls
  assign dis_n = dis_oe_n | dis_o;

  modport dev (input h2d_byte, h2d_valid, dis_n, escrow,
               output d_rx_ready, d2h_byte, d2h_valid, credit_pulse, busy_n);
  modport host (output h2d_byte, h2d_valid, dis_o, dis_oe_n, escrow,
                input d_rx_ready, d2h_byte, d2h_valid, credit_pulse, busy_n);
endinterface // nvhi_if
`default_nettype wire

//--- rtl/nvhi_host.sv
// Host controller end: APB registers drive commands, disable lines and
// escrow toggles; received bytes and credit pulses raise interrupts.
// Assumes an APB master on the same clock as the link.
`timescale 1ns/1ps
`default_nettype none
module nvhi_host (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Interrupt
  output logic             irq,
  // Link
  nvhi_if.host             lnk
);
  localparam int NS = nvhi_pkg::NSTAT;
  logic [7:0]  cmd_r, cmd_nxt, rx_r, rx_nxt;
  logic        cmdv_r, cmdv_nxt, hv_r, hv_nxt;
  logic [NS-1:0] st_r, st_nxt, mk_r, mk_nxt;
  logic [3:0]  en_r, en_nxt;
  logic        esc_r, esc_nxt, irq_r, irq_nxt;
  logic [15:0] tg_r, tg_nxt;
  logic [31:0] pc_r, pc_nxt, rd_r, rd_nxt;
  logic        rdy_r, rdy_nxt, err_r, err_nxt, pp_r, bz_r;

  // Register access, command issue, escrow toggle and event capture
  always_comb begin
    logic setup, wr, rd;
    logic [NS-1:0] ev;
    setup = psel & ~penable & ~rdy_r;
    wr = setup & pwrite;
    rd = setup & ~pwrite;
    cmd_nxt = cmd_r; cmdv_nxt = cmdv_r; rx_nxt = rx_r; hv_nxt = 1'b0;
    mk_nxt = mk_r; en_nxt = en_r; esc_nxt = esc_r; tg_nxt = tg_r; pc_nxt = pc_r;
    rdy_nxt = setup; err_nxt = 1'b0; rd_nxt = rd_r;
    ev = '0;
    // Send a pending command once the device can take it
    if (cmdv_r && lnk.d_rx_ready && !hv_r) begin
      hv_nxt = 1'b1; cmdv_nxt = 1'b0; // R3 R4 R5 R6 R18
    end
    if (lnk.d2h_valid) begin rx_nxt = lnk.d2h_byte; ev[nvhi_pkg::S_RX] = 1'b1; end
    if (lnk.credit_pulse && !pp_r) begin pc_nxt = pc_r + 32'd1; ev[nvhi_pkg::S_PULSE] = 1'b1; end
    if (lnk.busy_n && !bz_r) ev[nvhi_pkg::S_IDLE] = 1'b1;
    // Escrow line: low for a fixed time, then high again
    if (tg_r != 16'd0) begin
      tg_nxt = tg_r - 16'd1;
      if (tg_r == 16'd1) esc_nxt = 1'b1; // R13 R19
    end
    if (wr) begin
      case (paddr)
        nvhi_pkg::A_CMD: begin
          if (cmdv_r) ev[nvhi_pkg::S_ERR] = 1'b1;
          else begin cmd_nxt = pwdata[7:0]; cmdv_nxt = 1'b1; end
        end
        nvhi_pkg::A_MASK: mk_nxt = pwdata[NS-1:0];
        nvhi_pkg::A_CTRL: begin
          en_nxt = pwdata[3:0]; // R8
          if (pwdata[nvhi_pkg::CTRL_TOG] && tg_r == 16'd0) begin
            esc_nxt = 1'b0; tg_nxt = 16'(nvhi_pkg::TOGGLE_CYC);
          end
        end
        nvhi_pkg::A_PULSES: pc_nxt = 32'd0;
        default: err_nxt = (paddr != nvhi_pkg::A_RXBYTE && paddr != nvhi_pkg::A_STAT);
      endcase
    end
    if (rd) begin
      case (paddr)
        nvhi_pkg::A_CMD:    rd_nxt = {23'h0, cmdv_r, cmd_r};
        nvhi_pkg::A_RXBYTE: rd_nxt = {24'h0, rx_r};
        nvhi_pkg::A_STAT:   rd_nxt = {{(32-NS){1'b0}}, st_r};
        nvhi_pkg::A_MASK:   rd_nxt = {{(32-NS){1'b0}}, mk_r};
        nvhi_pkg::A_CTRL:   rd_nxt = {27'h0, esc_r, en_r};
        nvhi_pkg::A_PULSES: rd_nxt = pc_r;
        default: begin rd_nxt = 32'h0000_0000; err_nxt = 1'b1; end
      endcase
    end
    // Read clears status, a same-cycle event still sets
    st_nxt = ((rd && paddr == nvhi_pkg::A_STAT) ? '0 : st_r) | ev;
    irq_nxt = |(st_nxt & mk_nxt);
  end

  // Registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_r <= 8'h00; cmdv_r <= 1'b0; rx_r <= 8'h00; hv_r <= 1'b0;
      st_r <= '0; mk_r <= '0; en_r <= 4'h0; esc_r <= 1'b1; tg_r <= 16'd0;
      pc_r <= 32'd0; rd_r <= 32'd0; rdy_r <= 1'b0; err_r <= 1'b0;
      irq_r <= 1'b0; pp_r <= 1'b0; bz_r <= 1'b1;
    end else begin
      cmd_r <= cmd_nxt; cmdv_r <= cmdv_nxt; rx_r <= rx_nxt; hv_r <= hv_nxt;
      st_r <= st_nxt; mk_r <= mk_nxt; en_r <= en_nxt; esc_r <= esc_nxt; tg_r <= tg_nxt;
      pc_r <= pc_nxt; rd_r <= rd_nxt; rdy_r <= rdy_nxt; err_r <= err_nxt;
      irq_r <= irq_nxt; pp_r <= lnk.credit_pulse; bz_r <= lnk.busy_n;
    end
  end

  // Enabled channels pull their line low; others float to the pull-up
  assign lnk.dis_o     = 4'h0;
  assign lnk.dis_oe_n  = ~en_r; // R8
  assign lnk.escrow    = esc_r;
  assign lnk.h2d_byte  = cmd_r;
  assign lnk.h2d_valid = hv_r;
  assign pready  = rdy_r;
  assign prdata  = rd_r;
  assign pslverr = err_r;
  assign irq     = irq_r;
endmodule // nvhi_host
`default_nettype wire

//--- dv/nvhi_props.sv
// Concurrent checks on the link between validator end and host end.
// Assumes the testbench instantiates it beside the interface.
`timescale 1ns/1ps
`default_nettype none
module nvhi_props (
  // Clock and reset
  input wire logic       pclk,
  input wire logic       presetn,
  // Link signals
  input wire logic [7:0] h2d_byte,
  input wire logic       h2d_valid,
  input wire logic       d_rx_ready,
  input wire logic [7:0] d2h_byte,
  input wire logic       d2h_valid,
  input wire logic       credit_pulse,
  input wire logic       busy_n
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Command taken by the device at this edge
  wire logic tk;
  assign tk = h2d_valid && d_rx_ready;

  // Echo needs two edges after the take: queue entry, then output flop
  chk_inhibit_echo:
    assert property (tk && h2d_byte inside {[8'h83:8'h92]}
      |-> ##2 d2h_valid && d2h_byte == $past(h2d_byte, 2)) else $error("inhibit echo wrong");
  chk_enable_echo:
    assert property (tk && h2d_byte inside {[8'h97:8'ha6]}
      |-> ##2 d2h_valid && d2h_byte == $past(h2d_byte, 2)) else $error("enable echo wrong");
  chk_status_frame:
    assert property (tk && h2d_byte == 8'hb6
      |-> ##2 (d2h_valid && d2h_byte == 8'hb6) ##1 d2h_valid [*3])
      else $error("status frame wrong");
  chk_status_flag:
    assert property (tk && h2d_byte == 8'hb6
      |-> ##5 d2h_valid && d2h_byte[7:1] == 7'h00) else $error("escrow flag not 0 or 1");
  chk_escrow_echo:
    assert property (tk && h2d_byte == 8'haa
      |-> ##2 d2h_valid && d2h_byte == 8'haa) else $error("escrow enable echo wrong");
  // Accept only means a held note while the device is busy
  chk_escrow_accept:
    assert property (tk && !busy_n && h2d_byte == 8'hac
      |-> ##2 (d2h_valid && d2h_byte == 8'hac) ##1 d2h_valid)
      else $error("escrow accept reply wrong");
  chk_busy_code_low:
    assert property (d2h_valid && d2h_byte == 8'h78 && !$past(d2h_valid)
      |-> !busy_n) else $error("busy code with busy line high");
  chk_pulse_busy:
    assert property ($rose(credit_pulse) |-> !busy_n) else $error("credit pulse while not busy");

  // Main scenarios reached
  cov_status: cover property (tk && h2d_byte == 8'hb6);
  cov_accept: cover property (tk && h2d_byte == 8'hac);
  cov_pulse: cover property ($rose(credit_pulse));
endmodule // nvhi_props
`default_nettype wire

//--- dv/tb_top.sv
// Testbench: validator end and host end joined by the link interface.
// Assumes the package, interface, both ends and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int LPE = 200;
  localparam int LPR = 50;
  localparam int ETO = 300;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        pready, pslverr, irq, perr, stack_o, return_o, blk, lp, cp_d = 1'b0;
  logic        pm = 1'b0, note_in = 1'b0, res_v = 1'b0, res_ok = 1'b0, ret_in = 1'b0;
  logic        sd = 1'b1;
  logic [7:0]  paddr = 8'h00, ppb = 8'h01, c;
  logic [31:0] pwdata = 32'h0, prdata, rd, j;
  logic [15:0] inh, mask, hi = 16'h0004;
  logic [3:0]  rch = 4'h0;
  logic [7:0]  q[$];
  int          n_fail = 0, samples_checked = 0, cyc = 0, n_pulse = 0, n_stack = 0, n_ret = 0;
  int          seed = 76362, s;

  nvhi_if lnk();
  nvhi_dev #(.LP_ENTRY(LPE), .LP_REENTRY(LPR), .ESC_TMO(ETO)) u_nvhi_dev (
    .pclk(pclk), .presetn(presetn), .lnk(lnk), .pulse_mode(pm), .pulse_escrow(1'b0),
    .credit_hold(pm), .low_power_en(1'b1), .start_disabled(sd), .pulses_per_burst(ppb),
    .pulse_hi_cyc(hi), .pulse_lo_cyc(16'h0003), .note_in(note_in), .result_valid(res_v),
    .result_ok(res_ok), .result_chan(rch), .result_bursts(5'h02), .note_returned(ret_in),
    .stack_o(stack_o), .return_o(return_o), .accept_block_o(blk), .low_power_o(lp),
    .chan_inhibit_o(inh));
  nvhi_host u_nvhi_host (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .irq(irq), .lnk(lnk));
  nvhi_props u_nvhi_props (
    .pclk(pclk), .presetn(presetn), .h2d_byte(lnk.h2d_byte), .h2d_valid(lnk.h2d_valid),
    .d_rx_ready(lnk.d_rx_ready), .d2h_byte(lnk.d2h_byte), .d2h_valid(lnk.d2h_valid),
    .credit_pulse(lnk.credit_pulse), .busy_n(lnk.busy_n));

  // 10 MHz clock
  always #50 pclk = ~pclk;
  // Byte capture, event counts and hang guard
  always @(posedge pclk) begin
    cp_d <= lnk.credit_pulse;
    cyc++;
    if (lnk.d2h_valid === 1'b1) q.push_back(lnk.d2h_byte);
    if (lnk.credit_pulse === 1'b1 && cp_d === 1'b0) n_pulse++;
    if (stack_o === 1'b1) n_stack++;
    if (return_o === 1'b1) n_ret++;
    if (cyc == 20000) begin
      n_fail++;
      end_of_test();
    end
  end

  task automatic end_of_test;
    if (n_fail == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // Holds the request until pready is seen high at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    perr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic cmd(input logic [7:0] b);
    apb(1'b1, nvhi_pkg::A_CMD, {24'h0, b});
  endtask
  // Next byte from the device, bounded wait
  task automatic rx(input logic [7:0] e);
    int k;
    k = 0;
    while (q.size() == 0 && k < 100) begin
      @(posedge pclk);
      k++;
    end
    chk({24'h0, (q.size() > 0) ? q.pop_front() : 8'hxx}, {24'h0, e});
  endtask
  task automatic do_reset;
    presetn <= 1'b0;
    tick(3);
    presetn <= 1'b1;
    q.delete();
    mask = '0;
  endtask
  // Serial note: inhibited channel is refused like an unknown note
  task automatic note(input logic [3:0] ch, input logic ok);
    note_in <= 1'b1;
    tick(1);
    note_in <= 1'b0;
    rx(8'h78);
    chk(lnk.busy_n, 1'b0);
    chk(lp, 1'b0);
    res_v  <= 1'b1;
    res_ok <= ok;
    rch    <= ch;
    tick(1);
    res_v <= 1'b0;
    rx(8'h79);
    if (ok && !mask[ch]) rx({4'h0, ch} + 8'h01);
    else begin
      rx(8'h14);
      ret_in <= 1'b1;
      tick(1);
      ret_in <= 1'b0;
      rx(8'h79);
    end
  endtask

  // Serial phase, then pulse phase with credit hold
  initial begin
    do_reset();
    tick(LPE - 20);
    chk(lp, 1'b0);
    tick(40);
    chk(lp, 1'b1);
    // Started disabled: refuse until the software enable arrives
    chk(blk, 1'b1);
    cmd(8'hb8);
    rx(8'hb8);
    chk(blk, 1'b0);
    for (int i = 0; i < 32; i++) begin
      c = (i < 16) ? 8'h97 + 8'(i) : 8'h83 + 8'(i - 16);
      cmd(c);
      rx(c);
      mask[i % 16] = (i >= 16);
      chk(inh, mask);
    end
    for (int i = 0; i < 10; i++) begin
      j = $random(seed);
      c = (j[4] ? 8'h83 : 8'h97) + {4'h0, j[3:0]};
      cmd(c);
      rx(c);
      mask[j[3:0]] = j[4];
      chk(inh, mask);
    end
    cmd(8'h97);
    rx(8'h97);
    mask[0] = 1'b0;
    note(4'h0, 1'b1);
    note(4'h0, 1'b0);
    for (int i = 0; i < 3; i++) begin
      j = $random(seed);
      note(j[3:0], j[4]);
      tick(3);
      chk(lnk.busy_n, 1'b1);
    end
    tick(LPR - 25);
    chk(lp, 1'b0);
    tick(45);
    chk(lp, 1'b1);
    cmd(8'haa);
    rx(8'haa);
    for (int i = 0; i < 4; i++) begin
      if (i == 0) cmd(8'hb6);
      rx(i == 0 ? 8'hb6 : i == 1 ? mask[7:0] : i == 2 ? mask[15:8] : 8'h01);
    end
    s = n_stack;
    note(4'h0, 1'b1);
    tick(5);
    chk(n_stack, s);
    cmd(8'hac);
    rx(8'hac);
    rx(8'h01);
    tick(3);
    chk(n_stack, s + 1);
    s = n_ret;
    note(4'h0, 1'b1);
    tick(ETO - 40);
    chk(n_ret, s);
    tick(80);
    chk(n_ret, s + 1);
    j = $random(seed);
    pm  <= 1'b1;
    sd  <= 1'b0;
    ppb <= {6'h0, j[1:0]} + 8'h01;
    hi  <= {14'h0, j[3:2]} + 16'h0002;
    do_reset();
    tick(8);
    chk(blk, 1'b1);
    apb(1'b1, nvhi_pkg::A_MASK, 32'h2);
    apb(1'b1, nvhi_pkg::A_CTRL, 32'h1);
    tick(8);
    chk(blk, 1'b0);
    note_in <= 1'b1;
    tick(1);
    note_in <= 1'b0;
    tick(5);
    res_v  <= 1'b1;
    res_ok <= 1'b1;
    rch    <= 4'h0;
    tick(1);
    res_v <= 1'b0;
    tick(100);
    chk(n_pulse, 0);
    chk({lnk.busy_n, blk, irq}, 3'b010);
    apb(1'b1, nvhi_pkg::A_CTRL, 32'h11);
    tick(1200);
    chk(n_pulse, ppb);
    chk({lnk.busy_n, blk, irq}, 3'b011);
    apb(1'b0, nvhi_pkg::A_STAT, 32'h0);
    chk(rd[1], 1'b1);
    tick(2);
    chk(irq, 1'b0);
    apb(1'b1, nvhi_pkg::A_CTRL, 32'h11);
    tick(1200);
    chk(n_pulse, 2 * ppb);
    chk(lnk.busy_n, 1'b1);
    apb(1'b0, nvhi_pkg::A_PULSES, 32'h0);
    chk(rd, 2 * ppb);
    apb(1'b0, 8'h40, 32'h0);
    chk({31'h0, perr}, 32'h1);
    chk(rd, 32'h0);
    end_of_test();
  end
endmodule // tb_top
`default_nettype wire
